// file: logic/nuf_target.sv
// Output byte FIFO and the command interpreter for unique-ID, parameter page and features.
`timescale 1ns/1ps
`default_nettype none
`include "nuf_consts.svh"

module nuf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    input wire logic flush,
    // Fill side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    wire logic push = in_valid && in_ready;
    wire logic pop = out_valid && out_ready;

    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem_reg[rd_ptr_reg];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else if (flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            if (pop) rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clk) begin
        if (push) mem_reg[wr_ptr_reg] <= in_data;
    end
endmodule // nuf_fifo

// Operation
// RULE1: Unique-ID, set and get features are taken only while all dies are idle.
// RULE2: Unique-ID command enters unique-ID mode until another valid command.
// RULE3: Unique-ID takes one zero address cycle, then busy for the array read time.
// RULE4: Host uses read-mode command after status polling to resume data output.
// RULE5: Unique-ID output is one byte per toggle async, one per edge sync.
// RULE6: Sixteen 32-byte copies, each 16 identifier bytes then their complement.
// RULE7: Host XORs copy halves, accepting only all-ones, else tries next copy.
// RULE8: Host may move column with plain change-read-column, never the enhanced one.
// RULE9: Feature commands take one address byte and move exactly four bytes.
// RULE10: Reset commands leave stored feature values unchanged unless noted.
// RULE11: Features decode at 01h, 10h, 80h, 81h, 89h, 90h; others reserved.
// RULE12: Set-features command enters set-features mode until another command.
// RULE13: Host waits the address-to-data interval before the first feature byte.
// RULE14: Feature bytes latch on write strobe rise async, data strobe rise sync.
// RULE15: Host repeats each sync feature byte on the following falling strobe edge.
// RULE16: Processing starts without waiting for the repeated copy of the last byte.
// RULE17: After four bytes, busy for the feature update time, visible in status.
// RULE18: Changing the interface type at 01h keeps busy for the interface change time.
// RULE19: Get-features command enters get-features mode until another valid command.
// RULE20: Get-features address is followed by busy for the feature update time.
// RULE21: Host never uses enhanced status read around get-features output.
// RULE22: Get-features output is one byte per toggle async, one per edge sync.
// RULE23: Parameter page repeats every 512 bytes; bytes 8704 to 8935 read all-ones.
// RULE24: Timing feature powers up as asynchronous interface, timing mode zero.
// RULE25: Reset under sync interface restores timing bits; under async it keeps them.
// RULE26: Reserved feature addresses ignore writes and read back zero bytes.
module nuf_target import nuf_pkg::*; #(
    parameter int ARRAY_READ_TIME_NS = 1000,
    parameter int FEATURE_UPDATE_TIME_NS = 1000,
    parameter int INTERFACE_CHANGE_TIME_NS = 1000,
    parameter logic [127:0] UNIQUE_ID = 128'h0123456789ABCDEF0F1E2D3C4B5A6978,
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Host pins.
    input wire logic ce_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic read_strobe_n,
    input wire logic dqs_in,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out,
    output logic dq_oe,
    output logic dqs_out,
    output logic dqs_oe,
    output logic ready_busy_n_out,
    output logic ready_busy_n_oe,
    // Die state from the array logic.
    input wire logic dies_idle
);
    // The identifier value above is arbitrary.
    localparam int ARRAY_READ_CYC = (ARRAY_READ_TIME_NS / `NUF_CLK_PERIOD_NS < 1) ? 1 :
        ARRAY_READ_TIME_NS / `NUF_CLK_PERIOD_NS;
    localparam int FEAT_CYC = (FEATURE_UPDATE_TIME_NS / `NUF_CLK_PERIOD_NS < 1) ? 1 :
        FEATURE_UPDATE_TIME_NS / `NUF_CLK_PERIOD_NS;
    localparam int ITC_CYC = (INTERFACE_CHANGE_TIME_NS / `NUF_CLK_PERIOD_NS < 1) ? 1 :
        INTERFACE_CHANGE_TIME_NS / `NUF_CLK_PERIOD_NS;

    // Pin synchronisers; a change counts only once the second and third stages agree.
    nuf_pins_t pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_reg, pin_prev_reg;
    wire nuf_pins_t pins_now = '{ce_n, cle, ale, we_n, read_strobe_n, dqs_in, dq_in};
    wire nuf_pins_t agree = ~(pin_s2_reg ^ pin_s3_reg);
    wire nuf_pins_t pin_next = (agree & pin_s3_reg) | (~agree & pin_reg);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1_reg <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00};
            pin_s2_reg <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00};
            pin_s3_reg <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00};
            pin_reg <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00};
            pin_prev_reg <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00};
        end else begin
            pin_s1_reg <= pins_now;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            pin_reg <= pin_next;
            pin_prev_reg <= pin_reg;
        end
    end

    // Registers and state.
    nuf_state_t state_reg, state_next;
    nuf_op_t op_reg, op_next;
    logic status_mode_reg, status_mode_next;
    logic [31:0] busy_cnt_reg, busy_cnt_next;
    logic [7:0] faddr_reg, faddr_next;
    logic [31:0] sf_buf_reg, sf_buf_next;
    logic [1:0] sf_cnt_reg, sf_cnt_next;
    logic [13:0] col_reg, col_next;
    logic [13:0] src_col_reg, src_col_next;
    logic col_hi_reg, col_hi_next;
    logic [7:0] dq_out_reg, dq_out_next;
    logic dqs_out_reg;
    logic dq_oe_reg, dqs_oe_reg, rb_oe_reg;
    logic [31:0] feat_reg [`NUF_FEAT_COUNT];

    // Strobe events seen on the synchronised pins.
    wire logic selected = !pin_reg.ce_n;
    wire logic we_rise = selected && pin_reg.we_n && !pin_prev_reg.we_n;
    wire logic dqs_rise = selected && pin_reg.dqs && !pin_prev_reg.dqs;
    wire logic re_fall = selected && !pin_reg.re_n && pin_prev_reg.re_n;
    wire logic re_edge = selected && (pin_reg.re_n != pin_prev_reg.re_n);
    wire logic [7:0] bus_byte = pin_reg.dq;
    wire logic if_sync = (feat_reg[0][`NUF_IF_LSB +: 2] == `NUF_IF_SYNC);
    wire logic cmd_ev = we_rise && pin_reg.cle && !pin_reg.ale;
    wire logic addr_ev = we_rise && pin_reg.ale && !pin_reg.cle;
    wire logic data_in_ev = !pin_reg.cle && !pin_reg.ale &&
        (if_sync ? dqs_rise : we_rise); // [RULE14]
    wire logic read_ev = if_sync ? re_edge : re_fall; // [RULE5] [RULE22]
    wire logic busy = (state_reg == NUF_BUSY);
    wire logic may_start = dies_idle && !busy; // [RULE1]

    // Command classification.
    wire logic is_reset_cmd = (bus_byte == `NUF_CMD_RESET_A) ||
        (bus_byte == `NUF_CMD_RESET_B) || (bus_byte == `NUF_CMD_RESET_C);
    wire logic is_uid_cmd = (bus_byte == `NUF_CMD_READ_UID);
    wire logic is_sf_cmd = (bus_byte == `NUF_CMD_SET_FEAT);
    wire logic is_gf_cmd = (bus_byte == `NUF_CMD_GET_FEAT);
    wire logic is_pp_cmd = (bus_byte == `NUF_CMD_READ_PPAGE);

    // Feature address decode; index 6 stands for every reserved address.
    wire logic [2:0] fidx;
    assign fidx = (faddr_reg == `NUF_FA_TIMING) ? 3'h0 :
        (faddr_reg == `NUF_FA_DRIVE) ? 3'h1 :
        (faddr_reg == `NUF_FA_DRIVE_ALT) ? 3'h2 :
        (faddr_reg == `NUF_FA_PULLDOWN) ? 3'h3 :
        (faddr_reg == `NUF_FA_RETRY) ? 3'h4 :
        (faddr_reg == `NUF_FA_ARRAY_MODE) ? 3'h5 : `NUF_FEAT_IDX_RESERVED; // [RULE11]
    wire logic fidx_valid = (fidx != `NUF_FEAT_IDX_RESERVED);
    wire logic [31:0] feat_rd = fidx_valid ? feat_reg[fidx] : 32'h00000000; // [RULE26]
    wire logic [31:0] sf_word = {bus_byte, sf_buf_reg[31:8]};
    wire logic sf_last = (state_reg == NUF_SF_DATA) && data_in_ev && (sf_cnt_reg == 2'h3);
    wire logic sf_write = sf_last && fidx_valid; // [RULE16] [RULE26]
    wire logic if_change = (fidx == `NUF_FEAT_IDX_TIMING) &&
        (sf_word[`NUF_IF_LSB +: 2] != feat_reg[0][`NUF_IF_LSB +: 2]);
    wire logic reset_ev = cmd_ev && is_reset_cmd;

    // Feature storage; a reset command restores only the timing field under sync.
    genvar gi;
    generate
        for (gi = 0; gi < `NUF_FEAT_COUNT; gi++) begin : g_feat
            localparam logic [31:0] RST_VAL = (gi == 0) ? `NUF_FEAT_RESET_TIMING :
                (gi == 1 || gi == 2) ? `NUF_FEAT_RESET_DRIVE : `NUF_FEAT_RESET_OTHER;
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    feat_reg[gi] <= RST_VAL; // [RULE24]
                end else if (sf_write && fidx == 3'(gi)) begin
                    feat_reg[gi] <= sf_word; // [RULE9]
                end else if (gi == 0 && reset_ev && if_sync) begin
                    feat_reg[gi] <= (feat_reg[gi] & ~`NUF_TM_FIELD_MASK) |
                        (RST_VAL & `NUF_TM_FIELD_MASK); // [RULE25] [RULE10]
                end
            end
        end
    endgenerate

    // Byte source for the output path.
    function automatic logic [7:0] uid_byte(input logic [13:0] col);
        logic [7:0] b;
        b = UNIQUE_ID[8*(15 - col[3:0]) +: 8];
        return col[4] ? ~b : b; // [RULE6]
    endfunction

    function automatic logic [7:0] ppage_byte(input logic [13:0] col);
        logic [8:0] off;
        off = col[8:0];
        if (col >= 14'(`NUF_PP_FF_START)) return 8'hFF; // [RULE23]
        case (off)
            9'd208: return 8'h01;
            9'd211: return 8'h28;
            9'd212: return 8'h0A;
            9'd213: return 8'h64;
            9'd215: return 8'h03;
            9'd216: return 8'h03;
            9'd420: return 8'h02;
            9'd422: return 8'h08;
            default: return 8'h00;
        endcase
    endfunction

    wire logic [7:0] src_byte = (op_reg == NUF_OP_UID) ? uid_byte(src_col_reg) :
        (op_reg == NUF_OP_PP) ? ppage_byte(src_col_reg) :
        feat_rd[8*src_col_reg[1:0] +: 8];
    wire logic src_more = (op_reg == NUF_OP_UID) ||
        (op_reg == NUF_OP_PP && src_col_reg < 14'(`NUF_PP_END)) ||
        (op_reg == NUF_OP_GF && src_col_reg < 14'(`NUF_FEAT_BYTES)); // [RULE9]
    wire logic src_valid = (state_reg == NUF_OUT) && src_more;
    wire logic src_ready;
    wire logic out_valid;
    wire logic [7:0] out_data;
    wire logic pop = (state_reg == NUF_OUT) && !status_mode_reg && read_ev && out_valid;
    logic flush;

    // Sixteen-copy unique-ID space wraps so reads past the end restart at copy zero.
    wire logic [13:0] src_col_inc = (op_reg == NUF_OP_UID) ?
        14'((src_col_reg + 14'h1) % 14'(`NUF_UID_SPAN)) : src_col_reg + 14'h1;

    nuf_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .flush(flush),
        .in_valid(src_valid),
        .in_ready(src_ready),
        .in_data(src_byte),
        .out_valid(out_valid),
        .out_ready(pop),
        .out_data(out_data)
    );

    // Command interpreter.
    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        status_mode_next = status_mode_reg;
        busy_cnt_next = busy_cnt_reg;
        faddr_next = faddr_reg;
        sf_buf_next = sf_buf_reg;
        sf_cnt_next = sf_cnt_reg;
        col_next = col_reg;
        col_hi_next = col_hi_reg;
        src_col_next = (src_valid && src_ready) ? src_col_inc : src_col_reg;
        flush = 1'b0;
        if (cmd_ev) begin
            if (bus_byte == `NUF_CMD_STATUS) begin
                status_mode_next = 1'b1;
            end else if (bus_byte == `NUF_CMD_READ_MODE && status_mode_reg) begin
                status_mode_next = 1'b0; // [RULE4]
            end else if (is_reset_cmd) begin
                state_next = NUF_IDLE;
                op_next = NUF_OP_NONE;
                status_mode_next = 1'b0;
                flush = 1'b1;
            end else if ((is_uid_cmd || is_sf_cmd || is_gf_cmd || is_pp_cmd) && may_start) begin
                flush = 1'b1;
                status_mode_next = 1'b0;
                if (is_uid_cmd) begin
                    state_next = NUF_UID_ADDR; // [RULE2]
                    op_next = NUF_OP_UID;
                end else if (is_sf_cmd) begin
                    state_next = NUF_SF_ADDR; // [RULE12]
                    op_next = NUF_OP_SF;
                end else if (is_gf_cmd) begin
                    state_next = NUF_GF_ADDR; // [RULE19]
                    op_next = NUF_OP_GF;
                end else begin
                    state_next = NUF_PP_ADDR;
                    op_next = NUF_OP_PP;
                end
            end else if (bus_byte == `NUF_CMD_COL_CHANGE && state_reg == NUF_OUT) begin
                state_next = NUF_COL_ADDR;
                col_hi_next = 1'b0;
            end else if (bus_byte == `NUF_CMD_COL_CONFIRM && state_reg == NUF_COL_ADDR) begin
                state_next = NUF_OUT;
                src_col_next = col_reg;
                flush = 1'b1;
            end
        end else begin
            case (state_reg)
                NUF_UID_ADDR, NUF_PP_ADDR: begin
                    if (addr_ev) begin
                        state_next = NUF_BUSY; // [RULE3]
                        busy_cnt_next = 32'(ARRAY_READ_CYC - 1);
                    end
                end
                NUF_SF_ADDR: begin
                    if (addr_ev) begin
                        faddr_next = bus_byte;
                        sf_cnt_next = 2'h0;
                        state_next = NUF_SF_DATA;
                    end
                end
                NUF_SF_DATA: begin
                    if (data_in_ev) begin
                        sf_buf_next = sf_word;
                        sf_cnt_next = sf_cnt_reg + 2'h1;
                        if (sf_last) begin
                            state_next = NUF_BUSY; // [RULE17]
                            busy_cnt_next = (sf_write && if_change) ?
                                32'(ITC_CYC - 1) : 32'(FEAT_CYC - 1); // [RULE18]
                        end
                    end
                end
                NUF_GF_ADDR: begin
                    if (addr_ev) begin
                        faddr_next = bus_byte;
                        state_next = NUF_BUSY; // [RULE20]
                        busy_cnt_next = 32'(FEAT_CYC - 1);
                    end
                end
                NUF_BUSY: begin
                    if (busy_cnt_reg == 32'h0) begin
                        state_next = (op_reg == NUF_OP_SF) ? NUF_IDLE : NUF_OUT;
                        src_col_next = 14'h0;
                        flush = 1'b1;
                    end else begin
                        busy_cnt_next = busy_cnt_reg - 32'h1;
                    end
                end
                NUF_COL_ADDR: begin
                    if (addr_ev) begin
                        col_hi_next = 1'b1;
                        if (col_hi_reg) col_next = {bus_byte[5:0], col_reg[7:0]};
                        else col_next = {col_reg[13:8], bus_byte};
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Output byte, strobe and pin enables; status reads bypass the FIFO.
    wire logic [7:0] status_byte = {1'b0, !busy, !busy, 5'h00};
    wire logic reading = selected && !pin_reg.cle && !pin_reg.ale && !pin_reg.re_n;
    always_comb begin
        dq_out_next = dq_out_reg;
        if (status_mode_reg && read_ev) dq_out_next = status_byte; // [RULE17]
        else if (pop) dq_out_next = out_data;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= NUF_IDLE;
            op_reg <= NUF_OP_NONE;
            status_mode_reg <= 1'b0;
            busy_cnt_reg <= 32'h00000000;
            faddr_reg <= 8'h00;
            sf_buf_reg <= 32'h00000000;
            sf_cnt_reg <= 2'h0;
            col_reg <= 14'h0000;
            col_hi_reg <= 1'b0;
            src_col_reg <= 14'h0000;
            dq_out_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            status_mode_reg <= status_mode_next;
            busy_cnt_reg <= busy_cnt_next;
            faddr_reg <= faddr_next;
            sf_buf_reg <= sf_buf_next;
            sf_cnt_reg <= sf_cnt_next;
            col_reg <= col_next;
            col_hi_reg <= col_hi_next;
            src_col_reg <= src_col_next;
            dq_out_reg <= dq_out_next;
        end
    end

    // In sync mode the data strobe toggles once per byte so both edges carry data.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dqs_out_reg <= 1'b0;
            dq_oe_reg <= 1'b0;
            dqs_oe_reg <= 1'b0;
            rb_oe_reg <= 1'b0;
        end else begin
            if (pop && if_sync) dqs_out_reg <= !dqs_out_reg; // [RULE5] [RULE22]
            dq_oe_reg <= reading && (state_reg == NUF_OUT || status_mode_reg);
            dqs_oe_reg <= selected && if_sync && state_reg == NUF_OUT;
            rb_oe_reg <= (state_next == NUF_BUSY);
        end
    end

    assign dq_out = dq_out_reg;
    assign dq_oe = dq_oe_reg;
    assign dqs_out = dqs_out_reg;
    assign dqs_oe = dqs_oe_reg;
    assign ready_busy_n_out = 1'b0;
    assign ready_busy_n_oe = rb_oe_reg;
endmodule // nuf_target
`default_nettype wire

// file: logic/nuf_consts.svh
// Constants for the unique-ID and feature command block: codes, addresses, layouts, timing.
`ifndef NUF_CONSTS_SVH
`define NUF_CONSTS_SVH

`define NUF_CLK_PERIOD_NS 10

`define NUF_CMD_READ_UID 8'hED
`define NUF_CMD_SET_FEAT 8'hEF
`define NUF_CMD_GET_FEAT 8'hEE
`define NUF_CMD_READ_PPAGE 8'hEC
`define NUF_CMD_STATUS 8'h70
`define NUF_CMD_READ_MODE 8'h00
`define NUF_CMD_RESET_A 8'hFF
`define NUF_CMD_RESET_B 8'hFC
`define NUF_CMD_RESET_C 8'hFA
`define NUF_CMD_COL_CHANGE 8'h05
`define NUF_CMD_COL_CONFIRM 8'hE0

`define NUF_UID_ADDR 8'h00

`define NUF_FA_TIMING 8'h01
`define NUF_FA_DRIVE 8'h10
`define NUF_FA_DRIVE_ALT 8'h80
`define NUF_FA_PULLDOWN 8'h81
`define NUF_FA_RETRY 8'h89
`define NUF_FA_ARRAY_MODE 8'h90

`define NUF_FEAT_COUNT 6
`define NUF_FEAT_IDX_TIMING 3'h0
`define NUF_FEAT_IDX_RESERVED 3'h6
`define NUF_FEAT_RESET_TIMING 32'h00000000
`define NUF_FEAT_RESET_DRIVE 32'h00000002
`define NUF_FEAT_RESET_OTHER 32'h00000000
`define NUF_TM_FIELD_MASK 32'h0000003F
`define NUF_IF_LSB 4
`define NUF_IF_SYNC 2'h1

`define NUF_UID_SPAN 512
`define NUF_PP_SLOT 512
`define NUF_PP_FF_START 8704
`define NUF_PP_END 8936
`define NUF_FEAT_BYTES 4

`define NUF_ST_RDY 6
`define NUF_ST_ARDY 5

`endif

// file: logic/nuf_pkg.sv
// Types shared by the unique-ID and feature command block.
`default_nettype none
package nuf_pkg;
    typedef struct packed {
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n;
        logic re_n;
        logic dqs;
        logic [7:0] dq;
    } nuf_pins_t;

    typedef enum logic [3:0] {
        NUF_IDLE, NUF_UID_ADDR, NUF_PP_ADDR, NUF_SF_ADDR, NUF_SF_DATA,
        NUF_GF_ADDR, NUF_BUSY, NUF_OUT, NUF_COL_ADDR
    } nuf_state_t;

    typedef enum logic [2:0] {NUF_OP_NONE, NUF_OP_UID, NUF_OP_PP, NUF_OP_SF, NUF_OP_GF} nuf_op_t;
endpackage
`default_nettype wire

// file: tb/nuf_host_model.sv
// Host controller model driving command, address, data and read strobe pins.
`timescale 1ns/1ps
`default_nettype none
module nuf_host_model (
    // Clock.
    input wire logic clk,
    // Host pins.
    output logic cle,
    output logic ale,
    output logic we_n,
    output logic read_strobe_n,
    output logic [7:0] dq,
    output logic dqs,
    input wire logic [7:0] dq_out
);
    initial begin
        {cle, ale, dq} = 10'h000;
        {we_n, read_strobe_n} = 2'h3;
        dqs = 1'b0;
    end
    // Levels are held six or eight cycles because the target needs four to see one.
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One write cycle; kind 2 is a command, 1 an address, 0 data.
    task automatic pin(input logic [1:0] kind, input logic [7:0] b);
        cle <= kind[1];
        ale <= kind[0];
        dq <= b;
        we_n <= 1'b0;
        hold(6);
        we_n <= 1'b1;
        hold(6);
        cle <= 1'b0;
        ale <= 1'b0;
        dq <= ~b;
        hold(2);
    endtask
    // One read toggle; the byte is taken while the strobe is still low.
    task automatic rd(output logic [7:0] b);
        read_strobe_n <= 1'b0;
        hold(8);
        b = dq_out;
        read_strobe_n <= 1'b1;
        hold(8);
    endtask
    task automatic ddr(input logic [7:0] b);
        dq <= b;
        dqs <= 1'b1;
        hold(6);
        dqs <= 1'b0;
        hold(6);
    endtask
endmodule // nuf_host_model
`default_nettype wire

// file: tb/nuf_target_properties.sv
// Pin-level checker for the unique-ID and feature target.
`timescale 1ns/1ps
`default_nettype none
module nuf_target_properties (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Host pins.
    input wire logic cle,
    input wire logic ale,
    input wire logic read_strobe_n,
    input wire logic [7:0] dq_out,
    input wire logic dq_oe,
    input wire logic dqs_out,
    input wire logic dqs_oe,
    input wire logic ready_busy_n_out,
    input wire logic ready_busy_n_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence busy_start;
        $rose(ready_busy_n_oe);
    endsequence
    sequence busy_done;
        ##[1:300] !ready_busy_n_oe;
    endsequence
    a_rb_open_drain: assert property (ready_busy_n_oe |-> !ready_busy_n_out)
        else $error("busy pin driven high");
    a_busy_min_len: assert property (busy_start |-> ready_busy_n_oe[*8])
        else $error("busy too short");
    a_busy_ends: assert property (busy_start |-> busy_done)
        else $error("busy never ends");
    a_dq_hold_idle: assert property (read_strobe_n[*8] |=> $stable(dq_out))
        else $error("output byte moved without a read");
    a_dqs_quiet: assert property (!dqs_oe && !$past(dqs_oe) |-> $stable(dqs_out))
        else $error("data strobe toggled while not driven");
    a_busy_no_dqs: assert property (ready_busy_n_oe |-> !dqs_oe)
        else $error("data strobe driven while busy");
    a_dq_oe_read: assert property (dq_oe |-> !cle && !ale)
        else $error("data driven during a command cycle");
    a_reset_quiet: assert property ($rose(arst_n) |-> !ready_busy_n_oe && !dq_oe && !dqs_oe)
        else $error("output active right after reset");
endmodule // nuf_target_properties
bind nuf_target nuf_target_properties u_props (.clk(clk), .arst_n(arst_n), .cle(cle),
    .ale(ale), .read_strobe_n(read_strobe_n), .dq_out(dq_out), .dq_oe(dq_oe),
    .dqs_out(dqs_out), .dqs_oe(dqs_oe), .ready_busy_n_out(ready_busy_n_out),
    .ready_busy_n_oe(ready_busy_n_oe));
`default_nettype wire

// file: tb/test_nuf_target.sv
// Testbench for the unique-ID and feature command target.
`timescale 1ns/1ps
`default_nettype none
`include "nuf_consts.svh"
module test_nuf_target;
    localparam logic [127:0] UID = 128'h00112233445566778899AABBCCDDEEFF;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic dies_idle = 1'b1;
    logic cle, ale, we_n, rd_n, dqs, dq_oe, dqs_out, dqs_oe, rb_out, rb_oe;
    logic [7:0] dq_in, dq_out;
    int error_cnt = 0;
    int samples_checked = 0;
    always #5 clk = ~clk;
    nuf_host_model host (.clk(clk), .cle(cle), .ale(ale), .we_n(we_n), .read_strobe_n(rd_n),
        .dq(dq_in), .dqs(dqs), .dq_out(dq_out));
    nuf_target #(.ARRAY_READ_TIME_NS(300), .FEATURE_UPDATE_TIME_NS(300),
        .INTERFACE_CHANGE_TIME_NS(600), .UNIQUE_ID(UID)) dut (.clk(clk), .arst_n(arst_n),
        .ce_n(1'b0), .cle(cle), .ale(ale), .we_n(we_n), .read_strobe_n(rd_n), .dqs_in(dqs),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe),
        .ready_busy_n_out(rb_out), .ready_busy_n_oe(rb_oe), .dies_idle(dies_idle));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_busy(input logic exp_busy);
        int n = 0;
        while (rb_oe !== 1'b1 && n < 30) begin
            @(posedge clk);
            n++;
        end
        check("busy", rb_oe, exp_busy);
        while (rb_oe !== 1'b0 && n < 400) begin
            @(posedge clk);
            n++;
        end
        check("busy end", rb_oe, 1'b0);
    endtask
    task automatic setf(input logic [7:0] fa, input logic [31:0] v);
        host.pin(2'h2, `NUF_CMD_SET_FEAT);
        host.pin(2'h1, fa);
        for (int i = 0; i < 4; i++) host.pin(2'h0, v[8*i +: 8]);
        wait_busy(1'b1);
    endtask
    task automatic getf(input logic [7:0] fa, input logic [31:0] exp);
        logic [7:0] b;
        host.pin(2'h2, `NUF_CMD_GET_FEAT);
        host.pin(2'h1, fa);
        wait_busy(1'b1);
        host.pin(2'h2, `NUF_CMD_STATUS);
        host.rd(b);
        check("status", b, 8'h60);
        host.pin(2'h2, `NUF_CMD_READ_MODE);
        for (int i = 0; i < 4; i++) begin
            host.rd(b);
            check("feature byte", b, exp[8*i +: 8]);
        end
    endtask
    task automatic wrap_up();
        $display("Checked %0d, errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        logic [7:0] b;
        logic [7:0] first [16];
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk);
        getf(8'h01, `NUF_FEAT_RESET_TIMING);
        getf(8'h10, `NUF_FEAT_RESET_DRIVE);
        getf(8'h80, `NUF_FEAT_RESET_DRIVE);
        setf(8'h89, 32'h04030201);
        setf(8'h55, 32'hFFFFFFFF);
        setf(8'h01, 32'h00000003);
        host.pin(2'h2, `NUF_CMD_RESET_A);
        host.pin(2'h2, `NUF_CMD_RESET_B);
        host.pin(2'h2, `NUF_CMD_RESET_C);
        getf(8'h89, 32'h04030201);
        getf(8'h01, 32'h00000003);
        getf(8'h55, 32'h00000000);
        setf(8'h01, 32'h00000013);
        host.pin(2'h2, `NUF_CMD_SET_FEAT);
        host.pin(2'h1, 8'h81);
        for (int i = 1; i < 5; i++) host.ddr(8'(i));
        wait_busy(1'b1);
        host.pin(2'h2, `NUF_CMD_RESET_A);
        getf(8'h01, `NUF_FEAT_RESET_TIMING);
        getf(8'h81, 32'h04030201);
        // Dies busy elsewhere: the command must be dropped, not queued.
        dies_idle <= 1'b0;
        host.pin(2'h2, `NUF_CMD_GET_FEAT);
        host.pin(2'h1, 8'h10);
        wait_busy(1'b0);
        dies_idle <= 1'b1;
        host.pin(2'h2, `NUF_CMD_READ_UID);
        host.pin(2'h1, `NUF_UID_ADDR);
        wait_busy(1'b1);
        for (int i = 0; i < 32; i++) begin
            host.rd(b);
            check("uid byte", b, UID[127 - 8*(i%16) -: 8] ^ {8{i[4]}});
            if (i < 16) first[i] = b;
            else check("uid xor", first[i-16] ^ b, 8'hFF);
        end
        host.pin(2'h2, `NUF_CMD_COL_CHANGE);
        host.pin(2'h1, 8'h33);
        host.pin(2'h1, 8'h00);
        host.pin(2'h2, `NUF_CMD_COL_CONFIRM);
        host.rd(b);
        check("uid column", b, UID[103 -: 8] ^ 8'hFF);
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end
endmodule // test_nuf_target
`default_nettype wire
